// ==== hdl/pdcr_pkg.sv ====
/*
 * pdcr_pkg: register offsets, field layout and reset values of the
 * loop divider configuration bank.
 * assumes: byte-wide register port driven by the serial management logic.
 */
package pdcr_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_FB_HIGH = 8'h28;
    localparam logic [7:0] OFF_FB_MID = 8'h29;
    localparam logic [7:0] OFF_FB_LOW = 8'h2A;
    localparam logic [7:0] OFF_IN1_HIGH = 8'h2B;
    localparam logic [7:0] OFF_IN1_MID = 8'h2C;
    localparam logic [7:0] OFF_IN1_LOW = 8'h2D;
    localparam logic [7:0] OFF_IN2_HIGH = 8'h2E;
    localparam logic [7:0] OFF_IN2_MID = 8'h2F;
    localparam logic [7:0] OFF_IN2_LOW = 8'h30;
    localparam logic [7:0] RST_FB_HIGH = 8'hC0;
    localparam logic [7:0] RST_FB_MID = 8'h00;
    localparam logic [7:0] RST_FB_LOW = 8'hF9;
    localparam logic [7:0] RST_IN1_HIGH = 8'h00;
    localparam logic [7:0] RST_IN1_MID = 8'h00;
    localparam logic [7:0] RST_IN1_LOW = 8'h09;
    localparam logic [7:0] RST_IN2_HIGH = 8'h00;
    localparam logic [7:0] RST_IN2_MID = 8'h00;
    localparam logic [7:0] RST_IN2_LOW = 8'h00;
    localparam logic [7:0] MASK_FB_HIGH = 8'hEF;
    localparam logic [7:0] MASK_IN_HIGH = 8'h07;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [3:0] PRESCALE_BASE = 4'h4;
    localparam logic [2:0] READ_ZERO = 3'h0;
    typedef enum logic [1:0] {
        PDCR_IDLE = 2'b00,
        PDCR_HOLD = 2'b01,
        PDCR_COMMIT = 2'b10
    } pdcr_state_t;
endpackage : pdcr_pkg

// ==== hdl/pdcr_regs.sv ====
/*
 * pdcr_regs: divider configuration bank for one clock-multiplier loop.
 * Holds the prescaler, the main feedback ratio and two input ratios, and
 * presents each as a divide ratio to the loop, loading all groups when any group's low byte is written.
 * assumes: reg_wr/reg_rd strobes come from the serial management logic on clk.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 3-bit prescaler bits 7:5, codes give 4..11
// - 20-bit feedback field across three bytes
// - feedback ratio is field plus one, even only for an odd low byte
// - 19-bit first input divider, three bytes
// - input divider ratio is field plus one
// - second 19-bit input divider, same layout
module pdcr_regs
    import pdcr_pkg::*;
#(
    parameter int FB_W = 20,
    parameter int IN_W = 19
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    output logic [3:0] feedback_prescale_ratio,
    output logic [FB_W:0] feedback_main_ratio,
    output logic [IN_W:0] first_input_ratio,
    output logic [IN_W:0] second_input_ratio,
    output logic ratio_update
);
    logic [7:0] fb_high_q, fb_mid_q, fb_low_q;
    logic [7:0] in1_high_q, in1_mid_q, in1_low_q;
    logic [7:0] in2_high_q, in2_mid_q, in2_low_q;
    logic [7:0] rdata_q;
    logic hit_q;
    logic upd_q;
    pdcr_state_t state_q;
    logic [3:0] pre_q;
    logic [FB_W:0] fb_q;
    logic [IN_W:0] in1_q, in2_q;
    logic wr_any;
    logic wr_low;

    function automatic logic [20:0] plus_one(input logic [19:0] field);
        plus_one = {1'b0, field} + 21'h000001;
    endfunction : plus_one

    function automatic logic [3:0] prescale_ratio(input logic [7:0] high);
        prescale_ratio = PRESCALE_BASE + {1'b0, high[7:5]};
    endfunction : prescale_ratio

    // carry of the adder is kept, so an all-ones field gives the full power of two
    function automatic logic [FB_W:0] fb_ratio(input logic [7:0] high, input logic [7:0] mid,
                                               input logic [7:0] low);
        fb_ratio = (FB_W + 1)'(plus_one({high[3:0], mid, low}));
    endfunction : fb_ratio

    function automatic logic [IN_W:0] in_ratio(input logic [7:0] high, input logic [7:0] mid,
                                               input logic [7:0] low);
        in_ratio = (IN_W + 1)'(plus_one({1'b0, high[2:0], mid, low}));
    endfunction : in_ratio

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = addr >= OFF_FB_HIGH && addr <= OFF_IN2_LOW;
    endfunction : is_mapped

    // ratios seen straight out of reset, worked out once from the reset bytes
    localparam logic [3:0] PRE_RST = prescale_ratio(RST_FB_HIGH);
    localparam logic [FB_W:0] FB_RST = fb_ratio(RST_FB_HIGH, RST_FB_MID, RST_FB_LOW);
    localparam logic [IN_W:0] IN1_RST = in_ratio(RST_IN1_HIGH, RST_IN1_MID, RST_IN1_LOW);
    localparam logic [IN_W:0] IN2_RST = in_ratio(RST_IN2_HIGH, RST_IN2_MID, RST_IN2_LOW);

    assign wr_any = reg_wr && is_mapped(reg_addr);
    // the low byte closes a group, so commit only then
    assign wr_low = reg_wr && (reg_addr == OFF_FB_LOW || reg_addr == OFF_IN1_LOW
                               || reg_addr == OFF_IN2_LOW);

    // masking at write time keeps reserved bits reading back as zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fb_high_q <= RST_FB_HIGH;
            fb_mid_q <= RST_FB_MID;
            fb_low_q <= RST_FB_LOW;
            in1_high_q <= RST_IN1_HIGH;
            in1_mid_q <= RST_IN1_MID;
            in1_low_q <= RST_IN1_LOW;
            in2_high_q <= RST_IN2_HIGH;
            in2_mid_q <= RST_IN2_MID;
            in2_low_q <= RST_IN2_LOW;
        end else if (reg_wr) begin
            case (reg_addr)
                OFF_FB_HIGH: fb_high_q <= reg_wdata & MASK_FB_HIGH;
                OFF_FB_MID: fb_mid_q <= reg_wdata;
                OFF_FB_LOW: fb_low_q <= reg_wdata;
                OFF_IN1_HIGH: in1_high_q <= reg_wdata & MASK_IN_HIGH;
                OFF_IN1_MID: in1_mid_q <= reg_wdata;
                OFF_IN1_LOW: in1_low_q <= reg_wdata;
                OFF_IN2_HIGH: in2_high_q <= reg_wdata & MASK_IN_HIGH;
                OFF_IN2_MID: in2_mid_q <= reg_wdata;
                OFF_IN2_LOW: in2_low_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // shadow bytes of all groups move to the loop only once any group's low byte lands
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= PDCR_IDLE;
        end else begin
            case (state_q)
                PDCR_IDLE: state_q <= wr_low ? PDCR_COMMIT : (wr_any ? PDCR_HOLD : PDCR_IDLE);
                PDCR_HOLD: state_q <= wr_low ? PDCR_COMMIT : PDCR_HOLD;
                PDCR_COMMIT: state_q <= wr_low ? PDCR_COMMIT : (wr_any ? PDCR_HOLD : PDCR_IDLE);
                default: state_q <= PDCR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= PRE_RST;
            fb_q <= FB_RST;
            in1_q <= IN1_RST;
            in2_q <= IN2_RST;
            upd_q <= 1'b0;
        end else begin
            upd_q <= state_q == PDCR_COMMIT;
            if (state_q == PDCR_COMMIT) begin
                pre_q <= prescale_ratio(fb_high_q);
                fb_q <= fb_ratio(fb_high_q, fb_mid_q, fb_low_q);
                in1_q <= in_ratio(in1_high_q, in1_mid_q, in1_low_q);
                in2_q <= in_ratio(in2_high_q, in2_mid_q, in2_low_q);
            end
        end
    end

    // reads show the written bytes, not the applied ratios
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else begin
            hit_q <= reg_rd && is_mapped(reg_addr);
            if (reg_rd) begin
                case (reg_addr)
                    OFF_FB_HIGH: rdata_q <= fb_high_q;
                    OFF_FB_MID: rdata_q <= fb_mid_q;
                    OFF_FB_LOW: rdata_q <= fb_low_q;
                    OFF_IN1_HIGH: rdata_q <= in1_high_q;
                    OFF_IN1_MID: rdata_q <= in1_mid_q;
                    OFF_IN1_LOW: rdata_q <= in1_low_q;
                    OFF_IN2_HIGH: rdata_q <= in2_high_q;
                    OFF_IN2_MID: rdata_q <= in2_mid_q;
                    OFF_IN2_LOW: rdata_q <= in2_low_q;
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_hit = hit_q;
    assign feedback_prescale_ratio = pre_q;
    assign feedback_main_ratio = fb_q;
    assign first_input_ratio = in1_q;
    assign second_input_ratio = in2_q;
    assign ratio_update = upd_q;

    // a commit loads every group from the shadow bytes at one edge
    chk_prescale_range: assert property (@(posedge clk) disable iff (!resetn)
        pre_q >= 4'h4 && pre_q <= 4'hB) else $error("prescale ratio out of range");
    chk_prescale_commit: assert property (@(posedge clk) disable iff (!resetn)
        state_q == PDCR_COMMIT |=> pre_q == PRESCALE_BASE + {1'b0, $past(fb_high_q[7:5])})
        else $error("prescale ratio not taken from the shadow byte");
    chk_fb_commit: assert property (@(posedge clk) disable iff (!resetn)
        state_q == PDCR_COMMIT |=> fb_q == {1'b0, $past(fb_high_q[3:0]),
        $past(fb_mid_q), $past(fb_low_q)} + 21'h000001)
        else $error("feedback ratio not field plus one");
    chk_fb_stable: assert property (@(posedge clk) disable iff (!resetn)
        state_q != PDCR_COMMIT |=> $stable(fb_q)) else $error("feedback ratio moved early");
    chk_in_stable: assert property (@(posedge clk) disable iff (!resetn)
        state_q != PDCR_COMMIT |=> $stable(in1_q) && $stable(in2_q) && $stable(pre_q))
        else $error("input or prescale ratio moved early");
    chk_hold_no_commit: assert property (@(posedge clk) disable iff (!resetn)
        wr_any && !wr_low |=> state_q == PDCR_HOLD)
        else $error("partial write did not wait for its low byte");
    chk_in1_commit: assert property (@(posedge clk) disable iff (!resetn)
        state_q == PDCR_COMMIT |=> in1_q == {1'b0, $past(in1_high_q[2:0]),
        $past(in1_mid_q), $past(in1_low_q)} + 20'h00001)
        else $error("first input ratio wrong");
    chk_in2_commit: assert property (@(posedge clk) disable iff (!resetn)
        state_q == PDCR_COMMIT |=> in2_q == {1'b0, $past(in2_high_q[2:0]),
        $past(in2_mid_q), $past(in2_low_q)} + 20'h00001)
        else $error("second input ratio wrong");
    chk_in_high_mask: assert property (@(posedge clk) disable iff (!resetn)
        in1_high_q[7:3] == 5'h00 && in2_high_q[7:3] == 5'h00)
        else $error("input high reserved bits set");
    chk_fb_reserved: assert property (@(posedge clk) disable iff (!resetn)
        fb_high_q[4] == 1'b0) else $error("feedback reserved bit set");
    chk_fb_readback: assert property (@(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr == OFF_FB_MID |=> reg_rdata == $past(fb_mid_q) && reg_hit)
        else $error("feedback middle byte read back wrong");
    chk_in1_readback: assert property (@(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr == OFF_IN1_HIGH |=> reg_rdata == $past(in1_high_q) && reg_hit)
        else $error("first input high byte read back wrong");
    chk_low_commit: assert property (@(posedge clk) disable iff (!resetn)
        wr_low |=> state_q == PDCR_COMMIT ##1 ratio_update)
        else $error("low byte write did not commit");
    cov_fb_write: cover property (@(posedge clk) disable iff (!resetn)
        reg_wr && reg_addr == OFF_FB_HIGH ##[1:8] reg_wr && reg_addr == OFF_FB_LOW);
    cov_in2_write: cover property (@(posedge clk) disable iff (!resetn)
        reg_wr && reg_addr == OFF_IN2_LOW);
    cov_read_hit: cover property (@(posedge clk) disable iff (!resetn) reg_hit);
    cov_in1_commit: cover property (@(posedge clk) disable iff (!resetn)
        reg_wr && reg_addr == OFF_IN1_LOW ##2 ratio_update);
    cov_hold_commit: cover property (@(posedge clk) disable iff (!resetn)
        state_q == PDCR_HOLD ##[1:8] state_q == PDCR_COMMIT);
endmodule : pdcr_regs
`default_nettype wire

// ==== verif/pdcr_host.sv ====
/*
 * pdcr_host: host model that writes and reads the divider bank byte by byte.
 * assumes: the bank samples its register port on the rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pdcr_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one-cycle strobe; odd low-byte codes are the caller's duty
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= ~w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // released lines must not keep the last value
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : put
endmodule : pdcr_host
`default_nettype wire

// ==== verif/pdcr_regs_test.sv ====
/*
 * pdcr_regs_test: self-checking bench for the divider bank.
 * assumes: pdcr_host drives the register port.
 */
`timescale 1ns/1ps
`default_nettype none
module pdcr_regs_test
    import pdcr_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_hit, ratio_update;
    logic [3:0] pre;
    logic [20:0] fb;
    logic [19:0] in1, in2;
    int error_cnt = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    pdcr_host pdcr_host_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    pdcr_regs pdcr_regs_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .feedback_prescale_ratio(pre), .feedback_main_ratio(fb),
        .first_input_ratio(in1), .second_input_ratio(in2), .ratio_update(ratio_update));
    task automatic chk(input string n, input logic [20:0] e, input logic [20:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        pdcr_host_inst.put(a, 8'h00, 1'b0);
        #1;
        chk("reg_rdata", 21'(e), 21'(reg_rdata));
        chk("reg_hit", 21'(h), 21'(reg_hit));
    endtask : rd
    // low byte commits all groups; ratios and pulse show one edge after the write edge
    task automatic commit(input logic [7:0] a, input logic [7:0] d);
        pdcr_host_inst.put(a, d, 1'b1);
        @(posedge clk);
        #1;
        chk("ratio_update", 21'h1, 21'(ratio_update));
    endtask : commit
    task automatic t_reset();
        logic [7:0] e [9] = '{RST_FB_HIGH, RST_FB_MID, RST_FB_LOW, RST_IN1_HIGH,
            RST_IN1_MID, RST_IN1_LOW, RST_IN2_HIGH, RST_IN2_MID, RST_IN2_LOW};
        chk("prescale", 21'hA, 21'(pre));
        chk("fb", 21'hFA, fb);
        chk("in1", 21'hA, 21'(in1));
        chk("in2", 21'h1, 21'(in2));
        for (int i = 0; i < 9; i++) begin
            rd(OFF_FB_HIGH + 8'(i), e[i], 1'b1);
        end
    endtask : t_reset
    task automatic t_prescale();
        for (int c = 0; c < 8; c++) begin
            pdcr_host_inst.put(OFF_FB_HIGH, {3'(c), 5'h00}, 1'b1);
            commit(OFF_FB_LOW, 8'h01);
            chk("prescale", 21'(4 + c), 21'(pre));
            chk("fb", 21'h2, fb);
        end
    endtask : t_prescale
    task automatic t_coherent();
        pdcr_host_inst.put(OFF_FB_HIGH, 8'hF1, 1'b1);
        pdcr_host_inst.put(OFF_FB_MID, 8'h23, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        chk("fb", 21'h2, fb);
        commit(OFF_FB_LOW, 8'h45);
        chk("fb", 21'h12346, fb);
        chk("prescale", 21'hB, 21'(pre));
        rd(OFF_FB_HIGH, 8'hE1, 1'b1);
        pdcr_host_inst.put(OFF_IN1_HIGH, 8'hFF, 1'b1);
        pdcr_host_inst.put(OFF_IN1_MID, 8'hFF, 1'b1);
        commit(OFF_IN1_LOW, 8'hFF);
        chk("in1", 21'h80000, 21'(in1));
        rd(OFF_IN1_HIGH, 8'h07, 1'b1);
        pdcr_host_inst.put(OFF_IN2_HIGH, 8'hFD, 1'b1);
        pdcr_host_inst.put(OFF_IN2_MID, 8'h00, 1'b1);
        commit(OFF_IN2_LOW, 8'h00);
        chk("in2", 21'h50001, 21'(in2));
        chk("in1", 21'h80000, 21'(in1));
        rd(OFF_IN2_HIGH, 8'h05, 1'b1);
    endtask : t_coherent
    task automatic t_unmapped();
        pdcr_host_inst.put(8'h31, 8'h5A, 1'b1);
        rd(8'h31, 8'h00, 1'b0);
        rd(8'h27, 8'h00, 1'b0);
    endtask : t_unmapped
    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_prescale();
        t_coherent();
        t_unmapped();
        close_out();
    end
endmodule : pdcr_regs_test
`default_nettype wire
